// file: smc_pkg.sv
/*
 * Shared constants of the synthesizer main control block: the register map,
 * field positions, reset values and calibration timing.
 * Assumes a 200 MHz system clock and an APB register bus with 32-bit data.
 */
package smc_pkg;
  // Register map
  localparam logic [11:0] MAIN_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0003;

  // Field positions of main_control
  localparam int SOFT_RESET_BIT = 13;
  localparam int POWER_DOWN_BIT = 12;
  localparam int DUAL_RECAL_BIT = 9;
  localparam int DUAL_INIT_BIT = 7;
  localparam int SET_SELECT_BIT = 6;
  localparam int CAL_ENABLE_BIT = 0;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_POWERED_DOWN_BIT = 1;
  localparam int STAT_FIRST_CAL_BIT = 2;
  localparam int STAT_SECOND_CAL_BIT = 3;
  localparam int STAT_ACTIVE_SET_BIT = 4;
  localparam int STAT_NEED_RECAL_BIT = 5;

  // Calibration timing
  localparam int CLK_MHZ = 200;
  localparam int CAL_TIME_US = 10;
  localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    SMC_IDLE = 2'b00,
    SMC_CAL_ACTIVE = 2'b01,
    SMC_CAL_OTHER = 2'b10
  } smc_state_type;
endpackage : smc_pkg

// file: smc_apb_slave.sv
/*
 * APB slave front end: turns an APB transfer into a one-cycle write strobe
 * or read strobe with address and data. Always ready, no wait states.
 * Assumes a master that follows APB setup and access phases.
 */
`timescale 1ns/1ps
module smc_apb_slave (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] i_rdata,
  input wire logic i_addr_ok,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [11:0] o_addr,
  output logic [15:0] o_wdata
);
  logic access;

  // Access phase completes immediately
  assign access = i_psel & i_penable;
  assign o_pready = 1'b1;
  assign o_pslverr = access & ~i_addr_ok;
  assign o_addr = i_paddr;
  // Only the two low byte lanes hold the 16-bit word
  assign o_wdata = {i_pstrb[1] ? i_pwdata[15:8] : i_rdata[15:8],
                    i_pstrb[0] ? i_pwdata[7:0] : i_rdata[7:0]};
  assign o_wr_stb = access & i_pwrite & i_addr_ok;
  assign o_rd_stb = access & ~i_pwrite;

  // Read data registered once the setup phase names a read
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_prdata <= 32'h0;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      o_prdata <= i_addr_ok ? i_rdata : 32'h0;
    end
  end
endmodule : smc_apb_slave

// file: smc_cal_timer.sv
/*
 * Calibration timer: counts a fixed number of cycles after a start pulse
 * and pulses done in the cycle after the last one. A start while running restarts it.
 * Assumes start and abort come from the same clock domain.
 */
`timescale 1ns/1ps
module smc_cal_timer #(
  parameter int CYCLES = 2000
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_abort,
  output logic o_busy,
  output logic o_done
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic done_reg;

  // Load on start, count down to zero and hold
  assign count_next = i_abort ? 16'h0 :
                      i_start ? 16'(CYCLES) :
                      (count_reg != 16'h0) ? count_reg - 16'h1 : 16'h0;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      count_reg <= 16'h0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg <= ~i_abort & ~i_start & (count_reg == 16'h1);
    end
  end

  assign o_busy = count_reg != 16'h0;
  assign o_done = done_reg;
endmodule : smc_cal_timer

// file: smc_main_control.sv
/*
 * Main control word of a fractional-N synthesizer with its calibration
 * sequencer, reached over APB. Holds main_control at byte 0x000 and a
 * read-only status word at 0x004.
 * Assumes one 200 MHz clock, synchronous reset, and a host that keeps
 * the reserved fields as the control word expects.
 */
// Chosen here: register access over APB.
// Summary of operation
// - The control word sits at offset zero and resets to three.
// - Writing one to bit 13 resets every register except the APB read data, then clears itself.
// - Bit 12 high powers the device down; low restores operation.
// - Toggling bit 9 in a write with bit 12 clear recalibrates both configuration sets.
// - Bit 7 set at programming calibrates both sets, else only one.
// - Bit 6 selects the first set at zero and the second at one.
// - A write with bit 0 set and bit 12 clear starts calibration; clear skips it unless bit 9 toggles.
`timescale 1ns/1ps
module smc_main_control #(
  parameter int CAL_CYCLES = smc_pkg::CAL_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic o_power_down,
  output logic o_config_set_select,
  output logic o_cal_busy,
  output logic o_regs_reset
);
  logic wr_stb;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [31:0] rdata;
  logic addr_ok;
  logic ctrl_hit;
  logic ctrl_wr;
  logic soft_reset;
  logic timer_busy;
  logic timer_done;
  logic timer_start;
  logic timer_abort;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic soft_reset_reg;
  logic first_cal_reg;
  logic second_cal_reg;
  logic need_recal_reg;
  logic need_recal_next;
  logic first_cal_next;
  logic second_cal_next;
  logic pd_exit;
  logic recal_toggle;
  logic cal_request;
  logic want_both;
  logic want_both_reg;
  logic wr_soft_reset;
  logic wr_power_down;
  logic wr_dual_recal;
  logic wr_cal_enable;
  logic cur_power_down;
  logic cur_dual_recal;
  logic cur_set_select;
  logic cal_other;
  logic [31:0] status_word;
  smc_pkg::smc_state_type state_reg;
  smc_pkg::smc_state_type state_next;

  // Address decode shared by read and write paths
  function automatic logic is_offset(input logic [11:0] a,
                                     input logic [11:0] off);
    is_offset = (a == off);
  endfunction : is_offset

  assign ctrl_hit = is_offset(addr, smc_pkg::MAIN_CONTROL_OFFSET);
  assign addr_ok = ctrl_hit | is_offset(addr, smc_pkg::STATUS_OFFSET);
  assign ctrl_wr = wr_stb & ctrl_hit;

  smc_apb_slave u_apb (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .i_rdata(rdata),
    .i_addr_ok(addr_ok),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_prdata(o_prdata),
    .o_wr_stb(wr_stb),
    .o_rd_stb(),
    .o_addr(addr),
    .o_wdata(wdata)
  );

  // Soft reset acts one cycle after the write, like the pin reset
  assign soft_reset = soft_reset_reg;

  // Write value; the reset bit is cleared on the same edge and is never stored
  assign ctrl_next = ctrl_wr ? wdata : ctrl_reg;

  // Fields of the incoming and the stored word, named once
  assign wr_soft_reset = wdata[smc_pkg::SOFT_RESET_BIT];
  assign wr_power_down = wdata[smc_pkg::POWER_DOWN_BIT];
  assign wr_dual_recal = wdata[smc_pkg::DUAL_RECAL_BIT];
  assign wr_cal_enable = wdata[smc_pkg::CAL_ENABLE_BIT];
  assign cur_power_down = ctrl_reg[smc_pkg::POWER_DOWN_BIT];
  assign cur_dual_recal = ctrl_reg[smc_pkg::DUAL_RECAL_BIT];
  assign cur_set_select = ctrl_reg[smc_pkg::SET_SELECT_BIT];
  assign cal_other = state_reg == smc_pkg::SMC_CAL_OTHER;

  // Leaving power-down, or toggling the dual-set bit, needs a new run
  assign pd_exit = ctrl_wr & cur_power_down & ~wr_power_down;
  assign recal_toggle = ctrl_wr & ~wr_power_down
                        & (wr_dual_recal ^ cur_dual_recal);
  // A word written with calibration enabled starts a run; a word that
  // also powers down starts nothing, since the run would be lost anyway
  assign cal_request = ctrl_wr & ~wr_power_down
                       & (wr_cal_enable | recal_toggle);
  // Both sets when asked at initial programming or by a toggle
  assign want_both = (ctrl_next[smc_pkg::DUAL_INIT_BIT] & ~second_cal_reg)
                     | recal_toggle;

  // Calibrated flags; set by a finished pass wins over a clear
  always_comb begin
    first_cal_next = first_cal_reg;
    second_cal_next = second_cal_reg;
    need_recal_next = need_recal_reg;
    if (pd_exit | recal_toggle) begin
      first_cal_next = 1'b0;
      second_cal_next = 1'b0;
    end
    if (pd_exit) begin
      need_recal_next = 1'b1;
    end
    if (timer_done) begin
      if (cur_set_select ^ cal_other) begin
        second_cal_next = 1'b1;
      end else begin
        first_cal_next = 1'b1;
      end
      if (state_reg == smc_pkg::SMC_CAL_ACTIVE) begin
        need_recal_next = 1'b0;
      end
    end
  end

  // Sequencer: active set first, then the other set if asked for
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      smc_pkg::SMC_IDLE: begin
        if (cal_request) begin
          state_next = smc_pkg::SMC_CAL_ACTIVE;
        end
      end
      smc_pkg::SMC_CAL_ACTIVE: begin
        if (timer_done) begin
          state_next = want_both_reg ? smc_pkg::SMC_CAL_OTHER
                                     : smc_pkg::SMC_IDLE;
        end
      end
      smc_pkg::SMC_CAL_OTHER: begin
        if (timer_done) begin
          state_next = smc_pkg::SMC_IDLE;
        end
      end
      default: begin
        state_next = smc_pkg::SMC_IDLE;
      end
    endcase
    if (ctrl_wr & wr_power_down) begin
      state_next = smc_pkg::SMC_IDLE;
    end else if (cal_request) begin
      state_next = smc_pkg::SMC_CAL_ACTIVE;
    end
  end

  // Timer starts on entry to each calibrating state
  assign timer_start = (state_next != smc_pkg::SMC_IDLE)
                       & ((state_next != state_reg) | cal_request);
  assign timer_abort = state_next == smc_pkg::SMC_IDLE
                       && state_reg != smc_pkg::SMC_IDLE && !timer_done;

  smc_cal_timer #(
    .CYCLES(CAL_CYCLES)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_srst(i_srst | soft_reset),
    .i_start(timer_start),
    .i_abort(timer_abort),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // Control word, soft reset pulse and calibration state
  always_ff @(posedge i_mclk) begin
    if (i_srst | soft_reset) begin
      ctrl_reg <= smc_pkg::MAIN_CONTROL_RESET;
      soft_reset_reg <= 1'b0;
      state_reg <= smc_pkg::SMC_IDLE;
      first_cal_reg <= 1'b0;
      second_cal_reg <= 1'b0;
      need_recal_reg <= 1'b0;
      want_both_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      ctrl_reg[smc_pkg::SOFT_RESET_BIT] <= 1'b0;
      soft_reset_reg <= ctrl_wr & wr_soft_reset;
      state_reg <= state_next;
      first_cal_reg <= first_cal_next;
      second_cal_reg <= second_cal_next;
      need_recal_reg <= need_recal_next;
      if (cal_request) begin
        want_both_reg <= want_both;
      end
    end
  end

  // Status word: live view of the sequencer and the stored word
  always_comb begin
    status_word = 32'h0;
    status_word[smc_pkg::STAT_BUSY_BIT] = timer_busy;
    status_word[smc_pkg::STAT_POWERED_DOWN_BIT] = cur_power_down;
    status_word[smc_pkg::STAT_FIRST_CAL_BIT] = first_cal_reg;
    status_word[smc_pkg::STAT_SECOND_CAL_BIT] = second_cal_reg;
    status_word[smc_pkg::STAT_ACTIVE_SET_BIT] = cur_set_select;
    status_word[smc_pkg::STAT_NEED_RECAL_BIT] = need_recal_reg;
  end

  // Read mux; reserved bits read back as written
  assign rdata = ctrl_hit ? {16'h0, ctrl_reg} : status_word;

  // Device-facing outputs
  assign o_power_down = cur_power_down;
  assign o_config_set_select = cur_set_select;
  assign o_cal_busy = timer_busy;
  assign o_regs_reset = soft_reset_reg;
endmodule : smc_main_control

// file: smc_main_control_props.sv
/*
 * Checker for the synthesizer main control block, watching only the top
 * module's ports. Assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module smc_props_chk #(
  parameter int CAL_CYCLES = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic o_power_down,
  input wire logic o_config_set_select,
  input wire logic o_cal_busy,
  input wire logic o_regs_reset
);
  logic wr0;
  logic acc;
  logic [15:0] busy_run;
  assign acc = i_psel && i_penable;
  assign wr0 = acc && i_pwrite && i_paddr == 12'h000 && i_pstrb[1:0] == 2'h3;
  // Busy cycles in a row; a control write may restart the pass
  always_ff @(posedge i_mclk) begin
    if (i_srst || wr0 || !o_cal_busy) begin
      busy_run <= 16'h0;
    end else begin
      busy_run <= busy_run + 16'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Soft reset pulse, then the word back at its defaults
  sequence s_soft;
    wr0 && i_pwdata[13];
  endsequence
  sequence s_back;
    o_regs_reset ##1 (!o_power_down && !o_config_set_select);
  endsequence
  property p_ready;
    acc |-> o_pready;
  endproperty
  property p_err;
    acc && !(i_paddr inside {12'h000, 12'h004}) |-> o_pslverr;
  endproperty
  property p_pd;
    wr0 && !i_pwdata[13] |=> o_power_down == $past(i_pwdata[12]);
  endproperty
  property p_sel;
    wr0 && !i_pwdata[13] |=> o_config_set_select == $past(i_pwdata[6]);
  endproperty
  property p_soft;
    s_soft |=> s_back;
  endproperty
  property p_pulse;
    o_regs_reset |=> !o_regs_reset;
  endproperty
  property p_cal;
    wr0 && i_pwdata[0] && !i_pwdata[12] && !i_pwdata[13] |-> ##[1:2] o_cal_busy;
  endproperty
  property p_calen;
    busy_run <= 16'(CAL_CYCLES);
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err: assert property (p_err) else $error("no error on unmapped");
  a_pd: assert property (p_pd) else $error("power down mismatch");
  a_sel: assert property (p_sel) else $error("set select mismatch");
  a_soft: assert property (p_soft) else $error("soft reset failed");
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  a_cal: assert property (p_cal) else $error("calibration not started");
  a_calen: assert property (p_calen) else $error("calibration too long");
endmodule : smc_props_chk
bind smc_main_control smc_props_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_u (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_prdata(o_prdata), .o_power_down(o_power_down),
  .o_config_set_select(o_config_set_select), .o_cal_busy(o_cal_busy),
  .o_regs_reset(o_regs_reset));

// file: smc_host_model.sv
/*
 * Host controller model: an APB master with one transfer task.
 * Assumes the bench calls the task from a single process.
 */
`timescale 1ns/1ps
module smc_host_model (
  input wire logic i_mclk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  // Idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
    o_pstrb = 4'hf;
  end
  // One transfer; the wait is bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e, output logic hung);
    hung = 1'b1;
    @(posedge i_mclk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    for (int n = 0; n < 20 && hung; n++) begin
      @(posedge i_mclk);
      if (i_pready === 1'b1) begin
        q = i_prdata;
        e = i_pslverr;
        hung = 1'b0;
      end
    end
    // Released lines show garbage, not the last value
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : smc_host_model

// file: synth_main_control_register_bench.sv
/*
 * Self-checking bench for the main control block with the host model.
 * Assumes the calibration length parameter is shortened for simulation.
 */
`timescale 1ns/1ps
module synth_main_control_register_bench;
  localparam int CP = 4;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, pd, sel, busy, rrst, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [3:0] pstrb;
  logic [31:0] seed = 32'h1def;
  int bad_count = 0;
  int compares = 0;
  smc_main_control #(.CAL_CYCLES(CP)) dut_u (.i_mclk(i_mclk),
    .i_srst(i_srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .o_power_down(pd),
    .o_config_set_select(sel), .o_cal_busy(busy), .o_regs_reset(rrst));
  smc_host_model host_u (.i_mclk(i_mclk), .i_pready(pready),
    .i_pslverr(pslverr), .i_prdata(prdata), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_pstrb(pstrb));
  always #2.5 i_mclk = ~i_mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic hung;
    host_u.xfer(w, a, d, rq, re, hung);
    if (hung) begin
      bad_count++;
      conclude();
    end
  endtask : go
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    go(1'b0, a, 32'h0);
    chk(rq, exp);
  endtask : rd
  // Write the word, then count busy cycles against a window
  task automatic calw(input logic [15:0] d, input int lo, input int hi);
    int n;
    n = 0;
    go(1'b1, 12'h000, {16'h0000, d});
    repeat (4 * CP + 8) begin
      @(posedge i_mclk);
      if (busy === 1'b1) n++;
    end
    chk((n < lo || n > hi) ? n : lo, lo);
  endtask : calw
  initial begin
    logic [15:0] d;
    repeat (10) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    chk({28'h0, pd, sel, busy, rrst}, 32'h0);
    rd(12'h000, 32'h3);
    calw(16'h0083, 2 * CP, 2 * CP + 4);
    rd(12'h004, 32'h0c);
    calw(16'h0003, CP, CP + 2);
    calw(16'h0002, 0, 0);
    calw(16'h0202, 2 * CP, 2 * CP + 4);
    calw(16'h0042, 0, 2 * CP + 4);
    chk({31'h0, sel}, 32'h1);
    calw(16'h1043, 0, 0);
    chk({31'h0, pd}, 32'h1);
    repeat (20000) @(posedge i_mclk);
    calw(16'h0043, CP, 2 * CP + 4);
    chk({31'h0, pd}, 32'h0);
    rd(12'h004, 32'h18);
    go(1'b1, 12'h000, 32'h2043);
    @(posedge i_mclk);
    chk({31'h0, rrst}, 32'h1);
    @(posedge i_mclk);
    chk({30'h0, pd, sel}, 32'h0);
    rd(12'h000, 32'h3);
    rd(12'h004, 32'h0);
    // Random legal words; reserved fields always as the word expects
    repeat (12) begin
      seed = xs(seed);
      d = {3'h0, seed[12], 2'h0, seed[9], 1'b0, seed[7:6], 5'h01, seed[0]};
      go(1'b1, 12'h000, {16'h0000, d});
      @(posedge i_mclk);
      chk({30'h0, pd, sel}, {30'h0, d[12], d[6]});
      repeat (4 * CP + 8) @(posedge i_mclk);
      rd(12'h000, {16'h0000, d});
    end
    // Unmapped place: refused, no effect on the word
    go(1'b1, 12'h008, 32'hffff);
    chk({31'h0, re}, 32'h1);
    rd(12'h008, 32'h0);
    rd(12'h000, {16'h0000, d});
    conclude();
  end
endmodule : synth_main_control_register_bench
